//--- mel_pkg.sv
// How it works
// - Unmasked event asserts interrupt within 200 ms
// - Latch flag and interrupt within 200 ms
// - Receive loss flag within 100 ms, fast 1
// - Transmit failure flag within 200 ms
// - Read clears flags; interrupt drops within 0.5ms
// - Setting mask on set flag drops interrupt
// - Clearing mask on set flag raises interrupt
// - Lane disable turns output off, 100/3 ms
// - Lane enable restores output, 400/10 ms
// - Latency timing starts at end of write
// - Receive disable silences output within 100 ms
// - Receive enable restores output within 100 ms
// - Squelch disable write stops squelching, 100 ms
// - Squelch enable write resumes squelching, 100 ms
// - Receive auto squelch within 15 ms
// - Transmit auto squelch within 400 ms
// - Advertised times never exceed latency limits
// - Asserted is one; low pin when active-low
package mel_pkg;

   localparam int unsigned LANES = 4;
   localparam int unsigned NFLAG = 3 * LANES;
   localparam int unsigned AW = 8;
   localparam int unsigned DW = 32;
   localparam int unsigned ADV_W = 16;

   // Register byte addresses
   localparam logic [AW-1:0] ADDR_FLAG = 8'h00;
   localparam logic [AW-1:0] ADDR_MASK = 8'h04;
   localparam logic [AW-1:0] ADDR_TXDIS = 8'h08;
   localparam logic [AW-1:0] ADDR_RXDIS = 8'h0C;
   localparam logic [AW-1:0] ADDR_SQDIS = 8'h10;
   localparam logic [AW-1:0] ADDR_MODE = 8'h14;
   localparam logic [AW-1:0] ADDR_ADV = 8'h18;
   localparam logic [AW-1:0] ADDR_COND = 8'h1C;

   // Field positions inside flag, mask and condition words
   localparam int unsigned FLD_RXLOS = 0;
   localparam int unsigned FLD_TXFAIL = LANES;
   localparam int unsigned FLD_TXLOS = 2 * LANES;
   // Squelch disable word: receive lanes low, transmit lanes above
   localparam int unsigned SQ_RX = 0;
   localparam int unsigned SQ_TX = LANES;
   // Mode word
   localparam int unsigned MODE_RXFAST = 0;
   localparam int unsigned MODE_TXFAST = 1;
   localparam int unsigned MODE_W = 2;
   // Advertised time word
   localparam int unsigned ADV_OFF_LSB = 0;
   localparam int unsigned ADV_ON_LSB = 16;

   // Reset values
   localparam logic [NFLAG-1:0] MASK_RST = 12'h000;
   localparam logic [LANES-1:0] TXDIS_RST = 4'h0;
   localparam logic [LANES-1:0] RXDIS_RST = 4'h0;
   localparam logic [2*LANES-1:0] SQDIS_RST = 8'h00;
   localparam logic [MODE_W-1:0] MODE_RST = 2'h0;

   // Clock and latency limits
   localparam int unsigned CLK_MHZ = 25;
   localparam int unsigned T_IRQ_ON_US = 200000;
   localparam int unsigned T_LOS_US = 100000;
   localparam int unsigned T_LOSF_US = 1000;
   localparam int unsigned T_TXFAIL_US = 200000;
   localparam int unsigned T_IRQ_OFF_US = 500;
   localparam int unsigned T_MASK_US = 100000;
   localparam int unsigned T_TXDIS_US = 100000;
   localparam int unsigned T_TXDISF_US = 3000;
   localparam int unsigned T_TXEN_US = 400000;
   localparam int unsigned T_TXENF_US = 10000;
   localparam int unsigned T_RXDIS_US = 100000;
   localparam int unsigned T_SQDIS_US = 100000;
   localparam int unsigned T_RXSQ_US = 15000;
   localparam int unsigned T_TXSQ_US = 400000;
   localparam int unsigned US_PER_MS = 1000;

   // Worst latency this logic has from cause to pin, in cycles
   localparam int unsigned LAT_MAX_CYC = 6;

endpackage

//--- mel_top.sv
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module mel_top import mel_pkg::*; #(
   parameter int unsigned P_IRQ_ON_CYC = T_IRQ_ON_US * CLK_MHZ,
   parameter int unsigned P_LOS_CYC = T_LOS_US * CLK_MHZ,
   parameter int unsigned P_LOSF_CYC = T_LOSF_US * CLK_MHZ,
   parameter int unsigned P_TXFAIL_CYC = T_TXFAIL_US * CLK_MHZ,
   parameter int unsigned P_IRQ_OFF_CYC = T_IRQ_OFF_US * CLK_MHZ,
   parameter int unsigned P_MASK_CYC = T_MASK_US * CLK_MHZ,
   parameter int unsigned P_TXDISF_CYC = T_TXDISF_US * CLK_MHZ,
   parameter int unsigned P_TXENF_CYC = T_TXENF_US * CLK_MHZ,
   parameter int unsigned P_RXDIS_CYC = T_RXDIS_US * CLK_MHZ,
   parameter int unsigned P_SQDIS_CYC = T_SQDIS_US * CLK_MHZ,
   parameter int unsigned P_RXSQ_CYC = T_RXSQ_US * CLK_MHZ,
   parameter int unsigned P_TXSQ_CYC = T_TXSQ_US * CLK_MHZ
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Register port
   input wire logic [AW-1:0] i_addr,
   input wire logic [DW-1:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DW-1:0] o_rd_data,
   // Condition pins, asynchronous
   input wire logic [LANES-1:0] i_rx_los,
   input wire logic [LANES-1:0] i_tx_fail,
   input wire logic [LANES-1:0] i_tx_los,
   // Line side controls
   output logic [LANES-1:0] o_tx_lane_output_off,
   output logic [LANES-1:0] o_rx_output_squelch,
   // Interrupt pin
   output logic o_irq_line_low_active_n
);

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   wire hit_flag = (i_addr == ADDR_FLAG);
   wire hit_mask = (i_addr == ADDR_MASK);
   wire hit_txdis = (i_addr == ADDR_TXDIS);
   wire hit_rxdis = (i_addr == ADDR_RXDIS);
   wire hit_sqdis = (i_addr == ADDR_SQDIS);
   wire hit_mode = (i_addr == ADDR_MODE);
   wire hit_adv = (i_addr == ADDR_ADV);
   wire hit_cond = (i_addr == ADDR_COND);

   // Write completes in its strobe cycle; effects start from there
   wire wr_flag = i_wr & hit_flag;
   wire wr_mask = i_wr & hit_mask;
   wire wr_txdis = i_wr & hit_txdis;
   wire wr_rxdis = i_wr & hit_rxdis;
   wire wr_sqdis = i_wr & hit_sqdis;
   wire wr_mode = i_wr & hit_mode;
   wire rd_flag = i_rd & hit_flag;

   ////////////////////////////////////////////////////////////////////////////
   // Condition synchronisers: three stages, change taken when 2 and 3 agree

   logic [NFLAG-1:0] s1_q;
   logic [NFLAG-1:0] s2_q;
   logic [NFLAG-1:0] s3_q;
   logic [NFLAG-1:0] cond_q;

   wire [NFLAG-1:0] pin_all = {i_tx_los, i_tx_fail, i_rx_los};
   wire [NFLAG-1:0] cond_d = (s2_q & s3_q) | (cond_q & (s2_q | s3_q));
   wire [NFLAG-1:0] cond_rise = cond_d & ~cond_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         cond_q <= '0;
      end else begin
         s1_q <= pin_all;
         s2_q <= s1_q;
         s3_q <= s2_q;
         cond_q <= cond_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags: latched on onset, cleared on read or by writing ones; set wins

   logic [NFLAG-1:0] flag_q;
   logic [NFLAG-1:0] mask_q;

   wire [NFLAG-1:0] flag_clr = {NFLAG{rd_flag}} | ({NFLAG{wr_flag}} & i_wr_data[NFLAG-1:0]);
   wire [NFLAG-1:0] flag_d = (flag_q & ~flag_clr) | cond_rise;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flag_q <= '0;
      end else begin
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mask_q <= MASK_RST;
      end else if (wr_mask) begin
         mask_q <= i_wr_data[NFLAG-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: asserted as a low pin while any unmasked flag is set

   logic irq_q;
   wire irq_d = |(flag_q & ~mask_q);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign o_irq_line_low_active_n = ~irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Output disable, squelch disable and mode controls

   logic [LANES-1:0] txdis_q;
   logic [LANES-1:0] rxdis_q;
   logic [2*LANES-1:0] sqdis_q;
   logic [MODE_W-1:0] mode_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         txdis_q <= TXDIS_RST;
         rxdis_q <= RXDIS_RST;
         sqdis_q <= SQDIS_RST;
         mode_q <= MODE_RST;
      end else begin
         if (wr_txdis) begin
            txdis_q <= i_wr_data[LANES-1:0];
         end
         if (wr_rxdis) begin
            rxdis_q <= i_wr_data[LANES-1:0];
         end
         if (wr_sqdis) begin
            sqdis_q <= i_wr_data[2*LANES-1:0];
         end
         if (wr_mode) begin
            mode_q <= i_wr_data[MODE_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Line outputs: host disable, or auto squelch on lost input

   wire [LANES-1:0] rx_los_c = cond_q[FLD_RXLOS +: LANES];
   wire [LANES-1:0] tx_los_c = cond_q[FLD_TXLOS +: LANES];
   wire [LANES-1:0] rx_sq_off = sqdis_q[SQ_RX +: LANES];
   wire [LANES-1:0] tx_sq_off = sqdis_q[SQ_TX +: LANES];
   wire [LANES-1:0] rx_squelch_d = rxdis_q | (~rx_sq_off & rx_los_c);
   wire [LANES-1:0] tx_off_d = txdis_q | (~tx_sq_off & tx_los_c);

   logic [LANES-1:0] rx_squelch_q;
   logic [LANES-1:0] tx_off_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rx_squelch_q <= '0;
         tx_off_q <= '0;
      end else begin
         rx_squelch_q <= rx_squelch_d;
         tx_off_q <= tx_off_d;
      end
   end

   assign o_rx_output_squelch = rx_squelch_q;
   assign o_tx_lane_output_off = tx_off_q;

   ////////////////////////////////////////////////////////////////////////////
   // Advertised turn-off and turn-on times in ms, capped by the limits

   wire tx_fast = mode_q[MODE_TXFAST];
   wire [ADV_W-1:0] advertised_tx_turnoff_time = tx_fast ? ADV_W'(T_TXDISF_US / US_PER_MS)
                                                         : ADV_W'(T_TXDIS_US / US_PER_MS);
   wire [ADV_W-1:0] advertised_tx_turnon_time = tx_fast ? ADV_W'(T_TXENF_US / US_PER_MS)
                                                        : ADV_W'(T_TXEN_US / US_PER_MS);

   ////////////////////////////////////////////////////////////////////////////
   // Read data, valid the cycle after the strobe; unmapped reads give zero

   wire [DW-1:0] rv_flag = DW'(flag_q);
   wire [DW-1:0] rv_mask = DW'(mask_q);
   wire [DW-1:0] rv_txdis = DW'(txdis_q);
   wire [DW-1:0] rv_rxdis = DW'(rxdis_q);
   wire [DW-1:0] rv_sqdis = DW'(sqdis_q);
   wire [DW-1:0] rv_mode = DW'(mode_q);
   wire [DW-1:0] rv_adv = {advertised_tx_turnon_time, advertised_tx_turnoff_time};
   wire [DW-1:0] rv_cond = DW'(cond_q);
   wire [DW-1:0] rd_mux = hit_flag ? rv_flag :
                          hit_mask ? rv_mask :
                          hit_txdis ? rv_txdis :
                          hit_rxdis ? rv_rxdis :
                          hit_sqdis ? rv_sqdis :
                          hit_mode ? rv_mode :
                          hit_adv ? rv_adv :
                          hit_cond ? rv_cond : '0;

   logic [DW-1:0] rd_data_q;

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         rd_data_q <= '0;
      end else begin
         rd_data_q <= i_rd ? rd_mux : '0;
      end
   end

   assign o_rd_data = rd_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   property p_flag_onset;
      @(posedge i_clk) disable iff (!i_rst_n)
      (cond_rise != '0) |=> ((flag_q & $past(cond_rise)) == $past(cond_rise));
   endproperty
   a_flag_onset: assert property (p_flag_onset) else $error("flag not latched on onset");

   property p_irq_on_event;
      @(posedge i_clk) disable iff (!i_rst_n)
      ((cond_rise & ~mask_q) != '0) && !wr_mask |=> ##1 !o_irq_line_low_active_n;
   endproperty
   a_irq_on_event: assert property (p_irq_on_event) else $error("interrupt late after event");

   property p_rxlos_irq;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(s3_q[FLD_RXLOS]) && s2_q[FLD_RXLOS] && !mask_q[FLD_RXLOS] && !i_wr
      |=> flag_q[FLD_RXLOS] ##1 !o_irq_line_low_active_n;
   endproperty
   a_rxlos_irq: assert property (p_rxlos_irq) else $error("receive loss flag or interrupt late");

   property p_txfail_flag;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(cond_q[FLD_TXFAIL]) |-> flag_q[FLD_TXFAIL];
   endproperty
   a_txfail_flag: assert property (p_txfail_flag) else $error("transmit failure flag missing");

   property p_read_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_flag && (cond_rise == '0) |=> (flag_q == '0) ##1 o_irq_line_low_active_n;
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("interrupt not released after read");

   property p_mask_set;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_mask && (&i_wr_data[NFLAG-1:0]) |=> ##1 o_irq_line_low_active_n;
   endproperty
   a_mask_set: assert property (p_mask_set) else $error("interrupt not dropped by mask");

   property p_mask_clear;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_mask && (i_wr_data[NFLAG-1:0] == '0) && (flag_q != '0) |=> ##1 !o_irq_line_low_active_n;
   endproperty
   a_mask_clear: assert property (p_mask_clear) else $error("interrupt not raised by unmask");

   property p_irq_level;
      @(posedge i_clk) disable iff (!i_rst_n)
      ##1 (o_irq_line_low_active_n == !$past(irq_d));
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level mismatch");

   property p_tx_disable;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_txdis && i_wr_data[0] |=> ##1 o_tx_lane_output_off[0];
   endproperty
   a_tx_disable: assert property (p_tx_disable) else $error("lane output not turned off");

   property p_tx_enable;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_txdis && !i_wr_data[0] && !tx_los_c[0] && !$rose(s3_q[FLD_TXLOS]) && !s2_q[FLD_TXLOS]
      |=> ##1 !o_tx_lane_output_off[0];
   endproperty
   a_tx_enable: assert property (p_tx_enable) else $error("lane output not restored");

   property p_rx_disable;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_rxdis && i_wr_data[0] |=> ##1 o_rx_output_squelch[0];
   endproperty
   a_rx_disable: assert property (p_rx_disable) else $error("receive output not silenced");

   property p_rx_enable;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_rxdis && !i_wr_data[0] && !cond_q[FLD_RXLOS] && !cond_d[FLD_RXLOS] |=> ##1 !o_rx_output_squelch[0];
   endproperty
   a_rx_enable: assert property (p_rx_enable) else $error("receive output not restored");

   property p_sq_toggle;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_sqdis && !wr_rxdis && (rxdis_q[0] == 1'b0) && cond_q[FLD_RXLOS] && cond_d[FLD_RXLOS]
      |=> ##1 (o_rx_output_squelch[0] == !$past(i_wr_data[SQ_RX], 2));
   endproperty
   a_sq_toggle: assert property (p_sq_toggle) else $error("auto squelch change not applied");

   property p_rx_autosq;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(cond_q[FLD_RXLOS]) && !rx_sq_off[0] && !wr_sqdis |=> o_rx_output_squelch[0];
   endproperty
   a_rx_autosq: assert property (p_rx_autosq) else $error("receive squelch late");

   property p_tx_autosq;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(cond_q[FLD_TXLOS]) && !tx_sq_off[0] && !wr_sqdis |=> o_tx_lane_output_off[0];
   endproperty
   a_tx_autosq: assert property (p_tx_autosq) else $error("transmit squelch late");

   property p_adv_cap;
      @(posedge i_clk) disable iff (!i_rst_n)
      (32'(advertised_tx_turnoff_time) * US_PER_MS <= (tx_fast ? T_TXDISF_US : T_TXDIS_US))
      && (32'(advertised_tx_turnon_time) * US_PER_MS <= (tx_fast ? T_TXENF_US : T_TXEN_US));
   endproperty
   a_adv_cap: assert property (p_adv_cap) else $error("advertised time above limit");

   property p_budget;
      @(posedge i_clk) disable iff (!i_rst_n)
      (LAT_MAX_CYC <= P_LOSF_CYC) && (LAT_MAX_CYC <= P_IRQ_OFF_CYC) && (LAT_MAX_CYC <= P_TXDISF_CYC)
      && (LAT_MAX_CYC <= P_TXENF_CYC) && (LAT_MAX_CYC <= P_RXSQ_CYC) && (LAT_MAX_CYC <= P_SQDIS_CYC)
      && (LAT_MAX_CYC <= P_MASK_CYC) && (LAT_MAX_CYC <= P_RXDIS_CYC) && (LAT_MAX_CYC <= P_IRQ_ON_CYC)
      && (LAT_MAX_CYC <= P_LOS_CYC) && (LAT_MAX_CYC <= P_TXFAIL_CYC) && (LAT_MAX_CYC <= P_TXSQ_CYC);
   endproperty
   a_budget: assert property (p_budget) else $error("latency budget exceeded");

   property p_rd_value;
      @(posedge i_clk) disable iff (!i_rst_n)
      rd_flag |=> (o_rd_data == DW'($past(flag_q)));
   endproperty
   a_rd_value: assert property (p_rd_value) else $error("flag read returned wrong word");

   property p_w1c;
      @(posedge i_clk) disable iff (!i_rst_n)
      wr_flag && (cond_rise == '0) |=> ((flag_q & $past(i_wr_data[NFLAG-1:0])) == '0);
   endproperty
   a_w1c: assert property (p_w1c) else $error("written ones left flags set");

   property p_reset_out;
      @(posedge i_clk) disable iff (!i_rst_n)
      $rose(i_rst_n) |-> o_irq_line_low_active_n
      && (o_tx_lane_output_off == '0) && (o_rx_output_squelch == '0);
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not deasserted after reset");

   property p_mask_all;
      @(posedge i_clk) disable iff (!i_rst_n)
      (&mask_q) |=> o_irq_line_low_active_n;
   endproperty
   a_mask_all: assert property (p_mask_all) else $error("interrupt asserted while fully masked");

   property p_txfail_irq;
      @(posedge i_clk) disable iff (!i_rst_n)
      ((cond_rise[FLD_TXFAIL +: LANES] & ~mask_q[FLD_TXFAIL +: LANES]) != '0) && !wr_mask
      |=> ##1 !o_irq_line_low_active_n;
   endproperty
   a_txfail_irq: assert property (p_txfail_irq) else $error("transmit failure interrupt late");

   property p_rxsq_release;
      @(posedge i_clk) disable iff (!i_rst_n)
      $fell(cond_q[FLD_RXLOS]) && !rxdis_q[0] |=> !o_rx_output_squelch[0];
   endproperty
   a_rxsq_release: assert property (p_rxsq_release) else $error("receive squelch held after loss");

   c_flag_set: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(flag_q[FLD_RXLOS]));
   c_read_clear: cover property (@(posedge i_clk) disable iff (!i_rst_n) rd_flag && (flag_q != '0));
   c_irq_masked: cover property (@(posedge i_clk) disable iff (!i_rst_n) (flag_q != '0) && !irq_d);
   c_tx_off: cover property (@(posedge i_clk) disable iff (!i_rst_n) $rose(o_tx_lane_output_off[0]));
   c_sq_toggle: cover property (@(posedge i_clk) disable iff (!i_rst_n) wr_sqdis && cond_q[FLD_RXLOS]);

endmodule

//--- mel_host.sv
`timescale 1ns/1ps
module mel_host import mel_pkg::*; (
   // Clock
   input wire logic i_clk,
   // Register port toward the module
   output logic [AW-1:0] o_addr,
   output logic [DW-1:0] o_wr_data,
   output logic o_wr,
   output logic o_rd,
   input wire logic [DW-1:0] i_rd_data
);
   initial begin
      o_addr = 8'h00;
      o_wr_data = 32'h00000000;
      o_wr = 1'b0;
      o_rd = 1'b0;
   end

   ////////////////////////////////////////////////////////////////
   // Write: the strobe cycle is the end of the host transaction
   task automatic reg_write(input logic [AW-1:0] addr, input logic [DW-1:0] data);
      @(posedge i_clk);
      o_addr <= addr;
      o_wr_data <= data;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      // Released data shows the inverse so stale values are not mistaken for live ones
      o_wr_data <= ~data;
   endtask

   ////////////////////////////////////////////////////////////////
   // Read: data stand only in the cycle after the strobe; a flag read clears
   task automatic reg_read(input logic [AW-1:0] addr, output logic [DW-1:0] data);
      @(posedge i_clk);
      o_addr <= addr;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      #1;
      data = i_rd_data;
   endtask
endmodule

//--- mel_test.sv
`timescale 1ns/1ps
module mel_test import mel_pkg::*;;
   logic i_clk;
   logic i_rst_n;
   logic [AW-1:0] addr;
   logic [DW-1:0] wr_data;
   logic [DW-1:0] rd_data;
   logic wr_stb;
   logic rd;
   logic [LANES-1:0] rx_los;
   logic [LANES-1:0] tx_fail;
   logic [LANES-1:0] tx_los;
   logic [LANES-1:0] tx_off;
   logic [LANES-1:0] rx_sq;
   logic irq_n;
   int fails;
   int tests_run;
   logic [AW-1:0] zero_regs [8] = '{ADDR_FLAG, ADDR_MASK, ADDR_TXDIS, ADDR_RXDIS, ADDR_SQDIS, ADDR_MODE,
                                    ADDR_COND, 8'h20};

   initial i_clk = 1'b0;
   always #20 i_clk = ~i_clk;

   mel_top i_mel_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wr_data(wr_data), .i_wr(wr_stb),
      .i_rd(rd), .o_rd_data(rd_data), .i_rx_los(rx_los), .i_tx_fail(tx_fail), .i_tx_los(tx_los),
      .o_tx_lane_output_off(tx_off), .o_rx_output_squelch(rx_sq), .o_irq_line_low_active_n(irq_n));

   mel_host i_mel_host (.i_clk(i_clk), .o_addr(addr), .o_wr_data(wr_data), .o_wr(wr_stb), .o_rd(rd),
      .i_rd_data(rd_data));

   ////////////////////////////////////////////////////////////////
   task automatic check(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd_check(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      logic [DW-1:0] v;
      i_mel_host.reg_read(a, v);
      check(v, exp);
   endtask

   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      i_mel_host.reg_write(a, d);
   endtask

   // Worst design latency is fixed in cycles, so one settle covers every limit
   task automatic settle();
      repeat (LAT_MAX_CYC + 1) @(posedge i_clk);
      #1;
   endtask

   task automatic pin_check(input logic irq_exp, input logic [LANES-1:0] off_exp, input logic [LANES-1:0] sq_exp);
      check(DW'({irq_n, tx_off, rx_sq}), DW'({irq_exp, off_exp, sq_exp}));
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   initial begin
      #(6000 * 40);
      fails++;
      final_report();
   end

   initial begin
      fails = 0;
      tests_run = 0;
      i_rst_n = 1'b0;
      rx_los = 4'h0;
      tx_fail = 4'h0;
      tx_los = 4'h0;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      // Reset state, unmapped place and read-only advertised times
      pin_check(1'b1, 4'h0, 4'h0);
      for (int i = 0; i < 8; i++) begin
         rd_check(zero_regs[i], 32'h00000000);
      end
      rd_check(ADDR_ADV, 32'h01900064);
      wr(ADDR_ADV, 32'h00000000);
      wr(8'h20, 32'hFFFFFFFF);
      rd_check(ADDR_ADV, 32'h01900064);
      // Receive loss: flag, interrupt and auto squelch; clear on read
      @(posedge i_clk) rx_los <= 4'h1;
      settle();
      pin_check(1'b0, 4'h0, 4'h1);
      rd_check(ADDR_FLAG, 32'h00000001);
      rd_check(ADDR_FLAG, 32'h00000000);
      settle();
      pin_check(1'b1, 4'h0, 4'h1);
      rd_check(ADDR_COND, 32'h00000001);
      @(posedge i_clk) rx_los <= 4'h0;
      settle();
      pin_check(1'b1, 4'h0, 4'h0);
      // Transmit failure unmasked, then mask set, mask cleared, then write-one-to-clear
      @(posedge i_clk) tx_fail <= 4'h2;
      settle();
      pin_check(1'b0, 4'h0, 4'h0);
      wr(ADDR_MASK, 32'h00000020);
      settle();
      pin_check(1'b1, 4'h0, 4'h0);
      rd_check(ADDR_MASK, 32'h00000020);
      wr(ADDR_MASK, 32'h00000000);
      settle();
      pin_check(1'b0, 4'h0, 4'h0);
      wr(ADDR_FLAG, 32'h00000020);
      settle();
      pin_check(1'b1, 4'h0, 4'h0);
      rd_check(ADDR_FLAG, 32'h00000000);
      @(posedge i_clk) tx_fail <= 4'h0;
      // Fully masked event latches a flag but leaves the pin deasserted
      wr(ADDR_MASK, 32'h00000FFF);
      @(posedge i_clk) rx_los <= 4'h8;
      settle();
      pin_check(1'b1, 4'h0, 4'h8);
      wr(ADDR_MASK, 32'h00000000);
      settle();
      pin_check(1'b0, 4'h0, 4'h8);
      rd_check(ADDR_FLAG, 32'h00000008);
      @(posedge i_clk) rx_los <= 4'h0;
      settle();
      pin_check(1'b1, 4'h0, 4'h0);
      // Lane output disables, back to back writes
      wr(ADDR_TXDIS, 32'h0000000B);
      wr(ADDR_RXDIS, 32'h00000005);
      settle();
      pin_check(1'b1, 4'hB, 4'h5);
      wr(ADDR_TXDIS, 32'h00000000);
      wr(ADDR_RXDIS, 32'h00000000);
      settle();
      pin_check(1'b1, 4'h0, 4'h0);
      // Transmit auto squelch, disabled and re-enabled while loss persists
      @(posedge i_clk) tx_los <= 4'h5;
      settle();
      pin_check(1'b0, 4'h5, 4'h0);
      wr(ADDR_SQDIS, 32'h00000040);
      settle();
      pin_check(1'b0, 4'h1, 4'h0);
      wr(ADDR_SQDIS, 32'h00000000);
      settle();
      pin_check(1'b0, 4'h5, 4'h0);
      rd_check(ADDR_FLAG, 32'h00000500);
      @(posedge i_clk) tx_los <= 4'h0;
      settle();
      pin_check(1'b1, 4'h0, 4'h0);
      // Receive auto squelch disabled before the loss begins
      wr(ADDR_SQDIS, 32'h00000003);
      @(posedge i_clk) rx_los <= 4'h3;
      settle();
      pin_check(1'b0, 4'h0, 4'h0);
      rd_check(ADDR_SQDIS, 32'h00000003);
      wr(ADDR_SQDIS, 32'h00000000);
      settle();
      pin_check(1'b0, 4'h0, 4'h3);
      rd_check(ADDR_FLAG, 32'h00000003);
      @(posedge i_clk) rx_los <= 4'h0;
      // Transmit fast mode selects shorter advertised times; receive fast mode leaves them
      wr(ADDR_MODE, 32'h00000001);
      rd_check(ADDR_ADV, 32'h01900064);
      wr(ADDR_MODE, 32'h00000002);
      rd_check(ADDR_ADV, 32'h000A0003);
      wr(ADDR_MODE, 32'h00000003);
      rd_check(ADDR_MODE, 32'h00000003);
      // Reset in mid run drops every control and mask
      wr(ADDR_MASK, 32'h00000FFF);
      wr(ADDR_TXDIS, 32'h0000000F);
      @(posedge i_clk) i_rst_n <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      #1;
      pin_check(1'b1, 4'h0, 4'h0);
      rd_check(ADDR_MASK, 32'h00000000);
      rd_check(ADDR_ADV, 32'h01900064);
      final_report();
   end
endmodule
